// ===== rtl/ack_hold.sv
`timescale 1ns/1ns
module ack_hold
  import ctl_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic start_short,
  input  wire logic start_long,
  output logic      hold
);
  hold_state_t state_reg;
  logic [3:0]  cnt_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
    end else if (start_long) begin
      state_reg <= ST_HOLD;
      cnt_reg   <= HOLD_CYCLES;
    end else if (start_short) begin
      state_reg <= ST_HOLD;
      cnt_reg   <= LOC_HOLD_CYCLES;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 4'h0;
        end
        ST_HOLD: begin
          if (cnt_reg <= 4'h1) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 4'h0;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  assign hold = (state_reg == ST_HOLD);
endmodule

// ===== rtl/cpu_control_special_instr.sv
`timescale 1ns/1ns
module cpu_control_special_instr
  import ctl_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  // Instruction stream
  input  wire logic        INSTR_VALID,
  input  wire logic [3:0]  INSTR_OP,
  input  wire logic [15:0] INSTR_OPERAND,
  input  wire logic [2:0]  INSTR_BANK,
  // Port under check
  input  wire logic [7:0]  PIN_LEVEL,
  input  wire logic [7:0]  PIN_LEVEL_AGAIN,
  input  wire logic [7:0]  DRIVE_LEVEL,
  input  wire logic [7:0]  OUTPUT_MODE,
  input  wire logic        PORT_READ_CONTROL_BIT,
  input  wire logic        CHECK_PRESENT,
  // Interrupt request
  input  wire logic        INT_REQ,
  // State outputs
  output logic [23:0]      DATA_TOP,
  output logic             OPERAND_ERROR,
  output logic [2:0]       BANK_NUMBER_FIELD,
  output logic             REGISTER_SET_FLAG,
  output logic             INTERRUPT_ENABLE_FLAG,
  output logic             INT_ACK,
  output logic             FLAG_S,
  output logic             FLAG_Z,
  output logic             FLAG_PV,
  output logic [7:0]       A_VALUE,
  output logic             A_WRITE
);
  logic [7:0]  cmp_result;
  logic        loc_done_reg;
  logic        hold;
  logic        is_loc;
  logic        is_check;
  logic        is_bank;
  logic        is_bank_alt;
  logic        is_toggle;
  logic        is_allow;
  logic        is_block;
  logic        is_int_ctl;
  logic        is_check_acc;
  logic [7:0]  loc_xor;
  op_t         op;

  function automatic logic op_hit(input logic v, input op_t o, input op_t want);
    return v && (o == want);
  endfunction

  assign op           = op_t'(INSTR_OP);
  assign is_loc       = op_hit(INSTR_VALID, op, OP_LOCATION);
  assign is_bank      = op_hit(INSTR_VALID, op, OP_BANK);
  assign is_bank_alt  = op_hit(INSTR_VALID, op, OP_BANK_ALT);
  assign is_toggle    = op_hit(INSTR_VALID, op, OP_SET_TOGGLE);
  assign is_allow     = op_hit(INSTR_VALID, op, OP_INT_ALLOW);
  assign is_block     = op_hit(INSTR_VALID, op, OP_INT_BLOCK);
  assign is_int_ctl   = is_allow || is_block;
  assign is_check_acc = op_hit(INSTR_VALID, op, OP_CHECK_ACC);
  assign is_check     = op_hit(INSTR_VALID, op, OP_CHECK) || is_check_acc;
  assign loc_xor      = INSTR_OPERAND[15:8] ^ INSTR_OPERAND[7:0];

  pin_compare u_cmp (
    .pin_level       (PIN_LEVEL),
    .pin_level_again (PIN_LEVEL_AGAIN),
    .drive_level     (DRIVE_LEVEL),
    .output_mode     (OUTPUT_MODE),
    .read_ctl_bit    (PORT_READ_CONTROL_BIT),
    .check_present   (CHECK_PRESENT),
    .result          (cmp_result)
  );

  ack_hold u_hold (
    .clk         (CLK),
    .arst_n      (ARST_N),
    .start_short (is_loc),
    .start_long  (is_int_ctl),
    .hold        (hold)
  );

  // Data area location
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DATA_TOP     <= TOP_RESET;
      loc_done_reg <= 1'b0;
    end else if (is_loc && !loc_done_reg) begin
      loc_done_reg <= 1'b1;
      if (INSTR_OPERAND == LOC_CODE_LOW) begin
        DATA_TOP <= TOP_LOW;
      end else if (INSTR_OPERAND == LOC_CODE_HIGH) begin
        DATA_TOP <= TOP_HIGH;
      end
    end
  end

  // Operand error pulse
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      OPERAND_ERROR <= 1'b0;
    end else begin
      OPERAND_ERROR <= is_loc && (loc_xor != LOC_XOR_OK);
    end
  end

  // Register bank and set; no-op falls through untouched
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BANK_NUMBER_FIELD <= BANK_RESET;
      REGISTER_SET_FLAG <= 1'b0;
    end else if (INSTR_VALID) begin
      unique case (op)
        OP_BANK: begin
          BANK_NUMBER_FIELD <= INSTR_BANK;
          REGISTER_SET_FLAG <= 1'b0;
        end
        OP_BANK_ALT: begin
          BANK_NUMBER_FIELD <= INSTR_BANK;
          REGISTER_SET_FLAG <= 1'b1;
        end
        OP_SET_TOGGLE: begin
          REGISTER_SET_FLAG <= ~REGISTER_SET_FLAG;
        end
        default: begin
          REGISTER_SET_FLAG <= REGISTER_SET_FLAG;
        end
      endcase
    end
  end

  // Interrupt enable and acknowledge
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      INTERRUPT_ENABLE_FLAG <= 1'b0;
      INT_ACK               <= 1'b0;
    end else begin
      if (is_allow) begin
        INTERRUPT_ENABLE_FLAG <= 1'b1;
      end else if (is_block) begin
        INTERRUPT_ENABLE_FLAG <= 1'b0;
      end
      INT_ACK <= INT_REQ && INTERRUPT_ENABLE_FLAG && !hold && !is_loc && !is_int_ctl;
    end
  end

  // Flags from pin check; other instructions leave them alone
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FLAG_S  <= 1'b0;
      FLAG_Z  <= 1'b0;
      FLAG_PV <= 1'b0;
    end else if (is_check) begin
      FLAG_S  <= cmp_result[SIGN_BIT];
      FLAG_Z  <= (cmp_result == 8'h00);
      FLAG_PV <= parity_even(cmp_result);
    end
  end

  // Accumulator write
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      A_VALUE <= 8'h00;
      A_WRITE <= 1'b0;
    end else begin
      A_WRITE <= is_check_acc;
      if (is_check_acc) begin
        A_VALUE <= cmp_result;
      end
    end
  end


  sequence loc_taken_s;
    is_loc && !loc_done_reg;
  endsequence

  sequence no_ack_two_s;
    !INT_ACK ##1 !INT_ACK;
  endsequence

  sequence no_ack_three_s;
    !INT_ACK ##1 !INT_ACK ##1 !INT_ACK;
  endsequence

  // Location checks
  second_loc_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (is_loc && loc_done_reg) |=> $stable(DATA_TOP))
    else $error("Second location changed top");

  loc_code_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    loc_taken_s ##0 (INSTR_OPERAND == LOC_CODE_HIGH) |=> DATA_TOP == TOP_HIGH)
    else $error("Location high code missed");

  loc_low_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    loc_taken_s ##0 (INSTR_OPERAND == LOC_CODE_LOW) |=> DATA_TOP == TOP_LOW)
    else $error("Location low code missed");

  loc_bad_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (is_loc && INSTR_OPERAND != LOC_CODE_HIGH && INSTR_OPERAND != LOC_CODE_LOW)
    |=> $stable(DATA_TOP)) else $error("Bad location code acted");

  loc_once_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    loc_taken_s |=> loc_done_reg)
    else $error("Location one-shot not spent");

  done_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    loc_done_reg |=> loc_done_reg)
    else $error("Location one-shot rearmed");

  loc_only_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !is_loc |=> $stable(DATA_TOP))
    else $error("Top moved without location");

  top_legal_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    DATA_TOP == TOP_LOW || DATA_TOP == TOP_HIGH)
    else $error("Top holds illegal value");

  op_error_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (is_loc && loc_xor != LOC_XOR_OK) |=> OPERAND_ERROR)
    else $error("No operand error");

  op_error_ok_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !(is_loc && loc_xor != LOC_XOR_OK) |=> !OPERAND_ERROR)
    else $error("Spurious operand error");

  // Acknowledge checks
  loc_noack_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_loc |=> no_ack_two_s)
    else $error("Ack after location");

  ei_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_allow |=> INTERRUPT_ENABLE_FLAG ##0 no_ack_two_s)
    else $error("Ack too soon after allow");

  allow_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_allow |=> no_ack_three_s)
    else $error("Allow interval too short");

  block_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_block |=> no_ack_three_s)
    else $error("Block interval too short");

  block_clear_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_block |=> !INTERRUPT_ENABLE_FLAG)
    else $error("Block left enable set");

  ack_needs_ie_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    INT_ACK |-> $past(INTERRUPT_ENABLE_FLAG) && $past(INT_REQ))
    else $error("Ack without enable");

  ack_grant_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (INT_REQ && INTERRUPT_ENABLE_FLAG && !hold && !is_loc && !is_int_ctl) |=> INT_ACK)
    else $error("Ack withheld");

  ie_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !is_int_ctl |=> $stable(INTERRUPT_ENABLE_FLAG))
    else $error("Enable flag moved");

  // Bank and set checks
  bank_sel_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_bank |=> !REGISTER_SET_FLAG && BANK_NUMBER_FIELD == $past(INSTR_BANK))
    else $error("Bank choose wrong");

  bank_alt_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_bank_alt |=> REGISTER_SET_FLAG && BANK_NUMBER_FIELD == $past(INSTR_BANK))
    else $error("Alternate bank choose wrong");

  toggle_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_toggle |=> REGISTER_SET_FLAG != $past(REGISTER_SET_FLAG))
    else $error("Toggle failed");

  bank_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !(is_bank || is_bank_alt) |=> $stable(BANK_NUMBER_FIELD))
    else $error("Bank field moved");

  set_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !(is_bank || is_bank_alt || is_toggle) |=> $stable(REGISTER_SET_FLAG))
    else $error("Set flag moved");

  // Pin check flags
  flags_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !is_check |=> $stable(FLAG_Z) && $stable(FLAG_S))
    else $error("Flags moved");

  pv_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !is_check |=> $stable(FLAG_PV))
    else $error("Parity flag moved");

  zero_flag_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_check |=> FLAG_Z == ($past(cmp_result) == 8'h00))
    else $error("Zero flag wrong");

  sign_flag_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_check |=> FLAG_S == $past(cmp_result[SIGN_BIT]))
    else $error("Sign flag wrong");

  parity_flag_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_check |=> FLAG_PV == ~(^$past(cmp_result)))
    else $error("Parity flag wrong");

  mismatch_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (is_check && CHECK_PRESENT && !PORT_READ_CONTROL_BIT
    && ((PIN_LEVEL ^ DRIVE_LEVEL) & OUTPUT_MODE) != 8'h00) |=> !FLAG_Z) else $error("Mismatch hidden");

  read_ctl_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (is_check && CHECK_PRESENT && PORT_READ_CONTROL_BIT) |=> FLAG_Z)
    else $error("Read control did not hide mismatch");

  input_pin_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (is_check && CHECK_PRESENT) |-> (cmp_result & ~OUTPUT_MODE) == 8'h00)
    else $error("Input pin judged abnormal");

  twin_read_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (is_check && !CHECK_PRESENT && PIN_LEVEL == PIN_LEVEL_AGAIN) |=> FLAG_Z)
    else $error("Twin read not zero");

  // Accumulator checks
  acc_write_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    is_check_acc |=> A_WRITE && A_VALUE == $past(cmp_result))
    else $error("Accumulator not written");

  acc_idle_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !is_check_acc |=> !A_WRITE && $stable(A_VALUE))
    else $error("Accumulator written unasked");
endmodule

// ===== rtl/ctl_pkg.sv
// How it works
// - Location operand sets data area top
// - No acknowledge right after location instruction
// - Only first location after reset counts
// - Code 01FE selects 0H, 00FF 0FH
// - Unknown location code leaves data area top unchanged
// - Byte XOR not FF raises operand error
// - Bank choose clears set flag, loads bank
// - Alternate bank choose sets set flag
// - Toggle instruction inverts register set flag
// - No-operation changes nothing
// - Interrupt allow sets enable flag
// - Interrupt block clears enable flag
// - Acknowledge held off after allow/block
// - Check XORs pin level with driver
// - Sign flag equals result bit 7
// - Zero flag set when result zero
// - Parity flag set on even ones
// - Accumulator variant writes result to A
// - Read control bit set hides mismatch
// - Input-mode pins give zero when check present
// - Variant without check XORs two readings
package ctl_pkg;
  typedef enum logic [3:0] {
    OP_NOP        = 4'h0,
    OP_LOCATION   = 4'h1,
    OP_BANK       = 4'h2,
    OP_BANK_ALT   = 4'h3,
    OP_SET_TOGGLE = 4'h4,
    OP_INT_ALLOW  = 4'h5,
    OP_INT_BLOCK  = 4'h6,
    OP_CHECK      = 4'h7,
    OP_CHECK_ACC  = 4'h8
  } op_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HOLD  = 2'b01
  } hold_state_t;
  localparam logic [15:0] LOC_CODE_LOW  = 16'h01fe;
  localparam logic [15:0] LOC_CODE_HIGH = 16'h00ff;
  localparam logic [7:0]  LOC_XOR_OK    = 8'hff;
  localparam logic [23:0] TOP_LOW       = 24'h00ffff;
  localparam logic [23:0] TOP_HIGH      = 24'h0fffff;
  localparam logic [23:0] TOP_RESET     = 24'h00ffff;
  localparam logic [2:0]  BANK_RESET    = 3'h0;
  localparam logic [3:0]  HOLD_CYCLES   = 4'h2;
  localparam logic [3:0]  LOC_HOLD_CYCLES = 4'h1;
  localparam int          SIGN_BIT      = 7;
  function automatic logic parity_even(input logic [7:0] v);
    return ~(^v);
  endfunction
endpackage

// ===== rtl/pin_compare.sv
`timescale 1ns/1ns
module pin_compare
  import ctl_pkg::*;
(
  input  wire logic [7:0] pin_level,
  input  wire logic [7:0] pin_level_again,
  input  wire logic [7:0] drive_level,
  input  wire logic [7:0] output_mode,
  input  wire logic       read_ctl_bit,
  input  wire logic       check_present,
  output logic [7:0]      result
);
  logic [7:0] seen;
  always_comb begin
    seen   = read_ctl_bit ? drive_level : pin_level;
    result = (seen ^ drive_level) & output_mode;
    if (!check_present) begin
      result = pin_level ^ pin_level_again;
    end
  end
endmodule

// ===== testbench/port_pin_model.sv
`timescale 1ns/1ns
module port_pin_model (
  // Port driver side
  input  wire logic [7:0] drive_level,
  input  wire logic [7:0] output_mode,
  input  wire logic [7:0] fault_mask,
  // Pin levels seen by the core
  output logic      [7:0] pin_level,
  output logic      [7:0] pin_level_again
);
  // Output pins follow the driver unless a fault flips them; input pins show the inverse
  assign pin_level = (output_mode & (drive_level ^ fault_mask)) | (~output_mode & ~drive_level);
  // Output pins read the same twice; input pins may move between reads
  assign pin_level_again = pin_level ^ (~output_mode & fault_mask);
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import ctl_pkg::*;
  logic        clk, arst_n, valid, rc, present, req;
  logic [3:0]  op;
  logic [15:0] operand;
  logic [2:0]  bank, bnk, e_bank;
  logic [7:0]  drive, mode, fault, pin, pin2, aval;
  logic [23:0] top, e_top;
  logic        err, register_set_flag, ie, ack, fs, fz, fpv, aw;
  logic        e_rss, e_ie, e_s, e_z, e_pv, e_done;
  int          error_cnt = 0, cmp_count = 0, cyc = 0;

  port_pin_model pins_u (.drive_level(drive), .output_mode(mode), .fault_mask(fault),
    .pin_level(pin), .pin_level_again(pin2));
  cpu_control_special_instr dut_u (.CLK(clk), .ARST_N(arst_n), .INSTR_VALID(valid),
    .INSTR_OP(op), .INSTR_OPERAND(operand), .INSTR_BANK(bank), .PIN_LEVEL(pin),
    .PIN_LEVEL_AGAIN(pin2), .DRIVE_LEVEL(drive), .OUTPUT_MODE(mode),
    .PORT_READ_CONTROL_BIT(rc), .CHECK_PRESENT(present), .INT_REQ(req), .DATA_TOP(top),
    .OPERAND_ERROR(err), .BANK_NUMBER_FIELD(bnk), .REGISTER_SET_FLAG(register_set_flag),
    .INTERRUPT_ENABLE_FLAG(ie), .INT_ACK(ack), .FLAG_S(fs), .FLAG_Z(fz), .FLAG_PV(fpv),
    .A_VALUE(aval), .A_WRITE(aw));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim();
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] exp_res(input logic [7:0] p, p2, d, m, input logic r, c);
    if (!c) return p ^ p2;
    if (r) return 8'h00;
    return (p ^ d) & m;
  endfunction

  task automatic do_reset();
    op = OP_NOP;
    arst_n = 1'b0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    e_top = TOP_RESET;
    {e_bank, e_rss, e_ie, e_s, e_z, e_pv, e_done} = '0;
  endtask

  task automatic exec(input logic [3:0] o, input logic [15:0] d, input logic [2:0] b);
    logic [7:0] r;
    logic       bad;
    valid = 1'b1;
    op = o;
    operand = d;
    bank = b;
    #1;
    r = exp_res(pin, pin2, drive, mode, rc, present);
    bad = (o == OP_LOCATION) && ((d[15:8] ^ d[7:0]) != LOC_XOR_OK);
    case (o)
      OP_LOCATION: begin
        if (!e_done && d == LOC_CODE_LOW) e_top = TOP_LOW;
        if (!e_done && d == LOC_CODE_HIGH) e_top = TOP_HIGH;
        e_done = 1'b1;
      end
      OP_BANK, OP_BANK_ALT: begin
        e_bank = b;
        e_rss = (o == OP_BANK_ALT);
      end
      OP_SET_TOGGLE: e_rss = ~e_rss;
      OP_INT_ALLOW: e_ie = 1'b1;
      OP_INT_BLOCK: e_ie = 1'b0;
      OP_CHECK, OP_CHECK_ACC: {e_s, e_z, e_pv} = {r[SIGN_BIT], r == 8'h00, ~^r};
      default: ;
    endcase
    @(negedge clk);
    chk("data_top", e_top, top);
    chk("operand_error", 24'(bad), 24'(err));
    chk("bank_field", 24'(e_bank), 24'(bnk));
    chk("set_flag", 24'(e_rss), 24'(register_set_flag));
    chk("enable_flag", 24'(e_ie), 24'(ie));
    chk("flags", 24'({e_s, e_z, e_pv}), 24'({fs, fz, fpv}));
    chk("a_write", 24'(o == OP_CHECK_ACC), 24'(aw));
    if (o == OP_CHECK_ACC) chk("a_value", 24'(r), 24'(aval));
  endtask

  task automatic ack_check(input int n, input logic last);
    op = OP_NOP;
    for (int i = 0; i < n; i++) begin
      chk("int_ack_hold", 24'h0, 24'(ack));
      @(negedge clk);
    end
    chk("int_ack", 24'(last), 24'(ack));
  endtask

  initial begin
    void'($urandom(32702));
    {valid, op, operand, bank, drive, mode, fault, rc} = '0;
    present = 1'b1;
    req = 1'b1;
    do_reset();
    exec(OP_LOCATION, 16'h00ff, 3'h0);
    exec(OP_LOCATION, 16'h01fe, 3'h0);
    exec(OP_LOCATION, 16'h1234, 3'h0);
    do_reset();
    exec(OP_LOCATION, 16'h02fd, 3'h0);
    exec(OP_LOCATION, 16'h00ff, 3'h0);
    exec(OP_INT_ALLOW, 16'h0, 3'h0);
    ack_check(3, 1'b1);
    exec(OP_LOCATION, 16'h01fe, 3'h0);
    ack_check(2, 1'b1);
    exec(OP_INT_BLOCK, 16'h0, 3'h0);
    ack_check(3, 1'b0);
    for (int i = 0; i < 8; i++) begin
      exec(OP_BANK_ALT, 16'h0, 3'(i));
      exec(OP_SET_TOGGLE, 16'h0, 3'h0);
      exec(OP_BANK, 16'h0, 3'(7 - i));
    end
    drive = 8'ha5;
    mode = 8'hff;
    fault = 8'h81;
    exec(OP_CHECK_ACC, 16'h0, 3'h0);
    rc = 1'b1;
    exec(OP_CHECK_ACC, 16'h0, 3'h0);
    rc = 1'b0;
    mode = 8'h0f;
    exec(OP_CHECK, 16'h0, 3'h0);
    present = 1'b0;
    mode = 8'hff;
    exec(OP_CHECK_ACC, 16'h0, 3'h0);
    repeat (300) begin
      drive = 8'($urandom);
      mode = 8'($urandom);
      fault = ($urandom % 3 == 0) ? 8'($urandom) : 8'h00;
      rc = ($urandom % 5 == 0);
      present = ($urandom % 4 != 0);
      req = 1'($urandom);
      exec(4'($urandom % 9), ($urandom % 2) ? 16'h00ff : 16'($urandom), 3'($urandom));
    end
    end_sim();
  end
endmodule
